/* verilog/tcc_timer.sv */
// Timer counter with its control register, behind an AXI4-Lite slave
// Function
// - A two-bit source field picks the low-frequency oscillator, the pin, the system clock or the quarter clock.
// - With the pin selected, only rising edges of the pin advance the count.
// - A two-bit prescale field divides the count tick by 8, 4, 2 or 1.
// - A sync-bypass bit of 0 synchronises the pin input, 1 bypasses the synchroniser.
// - The 16-bit count rolls from ffff to 0000 and sets a sticky rollover flag that software clears.
// - While asleep the count runs only with the pin source in bypass mode, and a rollover then wakes the device.
`timescale 1ns/1ps
`include "tcc_defines.svh"

module tcc_timer
	import tcc_pkg::*;
#(
	parameter int LFOSC_DIV = `TCC_LFOSC_DIV
)(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Pins and system
	input  wire logic        external_count_input,
	input  wire logic        sleep,
	output logic             wake,
	output logic             irq
);

	if (LFOSC_DIV < 2 || LFOSC_DIV > 65535) begin : g_bad_lfosc_div
		$error("LFOSC_DIV out of range");
	end

	// ==================================================================
	// Registers
	logic [7:0]              timer_counter_control;
	logic [15:0]             count;
	logic [`TCC_ST_WIDTH-1:0] status;
	logic [`TCC_ST_WIDTH-1:0] mask;
	logic                    aw_held;
	logic                    w_held;
	logic [3:0]              aw_addr;
	logic [7:0]              w_byte0;
	logic [15:0]             w_data16;
	logic [3:0]              w_strb;

	wire tcc_src_t src        = tcc_src_t'(timer_counter_control[`TCC_SRC_HI:`TCC_SRC_LO]);
	wire tcc_ps_t  ps         = tcc_ps_t'(timer_counter_control[`TCC_PS_HI:`TCC_PS_LO]);
	wire           sync_bypass = timer_counter_control[`TCC_BYPASS_BIT];
	wire           counter_on  = timer_counter_control[`TCC_ON_BIT];

	// ==================================================================
	// Tick sources
	logic [1:0]  instr_div;
	logic [15:0] lfosc_div;
	logic        pin_sync1;
	logic        pin_sync2;
	logic        pin_prev;

	// Bypass skips the two-stage synchroniser: two cycles less latency, the pin must be clean
	wire pin_level   = sync_bypass ? external_count_input : pin_sync2;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instr_div <= 2'h0;
			lfosc_div <= 16'h0000;
			pin_sync1 <= 1'b0;
			pin_sync2 <= 1'b0;
			pin_prev  <= 1'b0;
		end else begin
			instr_div <= instr_div + 2'h1;
			lfosc_div <= (lfosc_div == 16'(LFOSC_DIV - 1)) ? 16'h0000 : lfosc_div + 16'h0001;
			pin_sync1 <= external_count_input;
			pin_sync2 <= pin_sync1;
			pin_prev  <= pin_level;
		end
	end

	wire pin_rise    = pin_level && !pin_prev;
	wire instr_tick  = (instr_div == 2'(`TCC_INSTR_DIV - 1));
	wire lfosc_tick  = (lfosc_div == 16'(LFOSC_DIV - 1));
	wire src_tick    = (src == TCC_SRC_LFOSC) ? lfosc_tick :
	                   (src == TCC_SRC_PIN)   ? pin_rise :
	                   (src == TCC_SRC_SYS)   ? 1'b1 : instr_tick;
	// Asleep, only the asynchronous counter keeps running
	wire sleep_ok    = !sleep || (sync_bypass && src == TCC_SRC_PIN);
	wire run         = counter_on && sleep_ok;
	logic count_tick;

	tcc_prescaler u_prescaler (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.run      (run),
		.ratio    (ps),
		.tick_in  (src_tick),
		.tick_out (count_tick)
	);

	wire rollover = count_tick && (count == 16'hffff);

	// ==================================================================
	// Bus decode
	wire do_write   = aw_held && w_held && !s_axi_bvalid;
	wire wr_ctrl    = do_write && (aw_addr == `TCC_OFF_CONTROL) && w_strb[0];
	wire wr_count   = do_write && (aw_addr == `TCC_OFF_COUNT);
	wire wr_status  = do_write && (aw_addr == `TCC_OFF_STATUS) && w_strb[0];
	wire wr_mask    = do_write && (aw_addr == `TCC_OFF_MASK) && w_strb[0];
	wire wr_mapped  = (aw_addr == `TCC_OFF_CONTROL) || (aw_addr == `TCC_OFF_COUNT) ||
	                  (aw_addr == `TCC_OFF_STATUS) || (aw_addr == `TCC_OFF_MASK);
	wire rd_take    = s_axi_arvalid && !s_axi_rvalid;
	wire rd_ctrl    = (s_axi_araddr == `TCC_OFF_CONTROL);
	wire rd_count   = (s_axi_araddr == `TCC_OFF_COUNT);
	wire rd_status  = (s_axi_araddr == `TCC_OFF_STATUS);
	wire rd_mask    = (s_axi_araddr == `TCC_OFF_MASK);
	wire rd_clear   = rd_take && rd_status;
	wire [31:0] rd_value = rd_ctrl   ? {24'h0, timer_counter_control} :
	                       rd_count  ? {16'h0, count} :
	                       rd_status ? {30'h0, status} :
	                       rd_mask   ? {30'h0, mask} : 32'h0;
	wire [15:0] strobed_count = {w_strb[1] ? w_data16[15:8] : count[15:8],
	                             w_strb[0] ? w_data16[7:0] : count[7:0]};
	wire [`TCC_ST_WIDTH-1:0] events = {rollover && sleep, rollover};

	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	assign irq           = |(status & mask);
	assign wake          = status[`TCC_ST_WAKE_BIT];

	// ==================================================================
	// Write channel capture and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 4'h0;
			w_byte0      <= 8'h00;
			w_data16     <= 16'h0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held   <= 1'b1;
				w_byte0  <= s_axi_wdata[7:0];
				w_data16 <= s_axi_wdata[15:0];
				w_strb   <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? 2'h0 : 2'h2;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ==================================================================
	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'h0;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_value;
			s_axi_rresp  <= (rd_ctrl || rd_count || rd_status || rd_mask) ? 2'h0 : 2'h2;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ==================================================================
	// Control, count, status and mask
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_counter_control <= `TCC_CTRL_RESET;
			count                 <= `TCC_COUNT_RESET;
			status                <= '0;
			mask                  <= `TCC_MASK_RESET;
		end else begin
			if (wr_ctrl)
				timer_counter_control <= w_byte0 & `TCC_CTRL_MASK;
			if (wr_count)
				count <= strobed_count;
			else if (count_tick)
				count <= count + 16'h0001;
			// Set beats clear when an event lands on the clearing read or write
			status <= (status & ~((rd_clear ? 2'h3 : 2'h0) | (wr_status ? w_byte0[1:0] : 2'h0)))
			          | events;
			if (wr_mask)
				mask <= w_byte0[1:0];
		end
	end

endmodule // tcc_timer

/* common/tcc_defines.svh */
// Constants for the timer counter control block: offsets, fields, resets, timing
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define TCC_OFF_CONTROL   4'h0
`define TCC_OFF_COUNT     4'h4
`define TCC_OFF_STATUS    4'h8
`define TCC_OFF_MASK      4'hc

// ==========================================================================
// Control field positions
`define TCC_SRC_HI        7
`define TCC_SRC_LO        6
`define TCC_PS_HI         5
`define TCC_PS_LO         4
`define TCC_BYPASS_BIT    2
`define TCC_ON_BIT        0
`define TCC_CTRL_MASK     8'hf5

// ==========================================================================
// Status and mask field positions
`define TCC_ST_ROLL_BIT   0
`define TCC_ST_WAKE_BIT   1
`define TCC_ST_WIDTH      2

// ==========================================================================
// Reset values
`define TCC_CTRL_RESET    8'h00
`define TCC_COUNT_RESET   16'h0000
`define TCC_MASK_RESET    2'h0

// ==========================================================================
// Timing
`define TCC_INSTR_DIV     4
`define TCC_LFOSC_DIV     806

`endif

/* common/tcc_pkg.sv */
// Types for the timer counter control block
package tcc_pkg;

	typedef enum logic [1:0] {
		TCC_SRC_INSTR = 2'b00,
		TCC_SRC_SYS   = 2'b01,
		TCC_SRC_PIN   = 2'b10,
		TCC_SRC_LFOSC = 2'b11
	} tcc_src_t;

	typedef enum logic [1:0] {
		TCC_PS_1 = 2'b00,
		TCC_PS_2 = 2'b01,
		TCC_PS_4 = 2'b10,
		TCC_PS_8 = 2'b11
	} tcc_ps_t;

endpackage

/* verilog/tcc_prescaler.sv */
// Prescaler dividing the selected count tick by 1, 2, 4 or 8
`timescale 1ns/1ps
`include "tcc_defines.svh"

module tcc_prescaler
	import tcc_pkg::*;
(
	// Clock and reset
	input  wire logic    aclk,
	input  wire logic    aresetn,
	// Control
	input  wire logic    run,
	input  wire tcc_ps_t ratio,
	input  wire logic    tick_in,
	// Divided tick
	output logic         tick_out
);

	logic [2:0] stage;
	logic [2:0] next_stage;
	wire  [2:0] last_value;

	// ==================================================================
	// Terminal count per ratio
	assign last_value = (ratio == TCC_PS_8) ? 3'h7 :
	                    (ratio == TCC_PS_4) ? 3'h3 :
	                    (ratio == TCC_PS_2) ? 3'h1 : 3'h0;
	assign next_stage = (stage >= last_value) ? 3'h0 : stage + 3'h1;
	assign tick_out   = run && tick_in && (stage >= last_value);

	// Stage is cleared while stopped so each start begins a full period
	always_ff @(posedge aclk) begin
		if (!aresetn || !run)
			stage <= 3'h0;
		else if (tick_in)
			stage <= next_stage;
	end

endmodule // tcc_prescaler

/* verif/tcc_timer_assertions.sv */
// Checker of the timer block bus handshakes and event outputs
`timescale 1ns/1ps
module tcc_timer_assertions (
	// Single-bit signals
	input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
	input wire logic s_axi_rready, external_count_input, sleep, wake, irq,
	// Buses
	input wire logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr,
	input wire logic [31:0] s_axi_wdata, s_axi_rdata,
	input wire logic [1:0]  s_axi_bresp, s_axi_rresp
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================
	// Assertions
	a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
		s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !irq && !wake)
		else $error("Outputs not idle after reset");
	a_aw_held: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("Write address not held");
	a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid) else $error("Late write response");
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped");
	a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Late read data");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("Read taken while busy");
	a_wake_cause: assert property ($rose(wake) |-> $past(sleep))
		else $error("Wake while awake");
	// ==========================================
	// Covers
	c_irq: cover property (irq);
	c_wake: cover property ($rose(wake));
	c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // tcc_timer_assertions

bind tcc_timer tcc_timer_assertions u_tcc_timer_assertions (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .external_count_input(external_count_input),
	.sleep(sleep), .wake(wake), .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_wstrb(s_axi_wstrb),
	.s_axi_araddr(s_axi_araddr), .s_axi_wdata(s_axi_wdata), .s_axi_rdata(s_axi_rdata),
	.s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp)
);

/* verif/tcc_timer_test.sv */
// Self-checking bench of the timer block
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tcc_timer_test import tcc_pkg::*; ;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic external_count_input, sleep;
	logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, rd, prev, exp;
	logic [1:0] s, p;
	logic [1:0] resp;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake, irq;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	int fails = 0;
	int total_checks = 0;
	// Short slow-oscillator divide keeps the run brief
	tcc_timer #(.LFOSC_DIV(4)) u_tcc_timer (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.external_count_input(external_count_input), .sleep(sleep), .wake(wake), .irq(irq)
	);
	initial begin
		aclk = 0;
		forever #20 aclk = ~aclk;
	end
	// ==========================================
	// Tasks
	task automatic summarize();
		$display("Checks %0d, errors %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want, input int tol);
		total_checks++;
		if ((^got) === 1'bx || got > want + tol || got + tol < want) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 0;
		w_done = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		// Each channel is released only at the edge that takes it
		while (!aw_done || !w_done) begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready) begin
				aw_done = 1;
				s_axi_awvalid <= 0;
			end
			if (!w_done && s_axi_wready) begin
				w_done = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rdr(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge aclk) external_count_input <= 1;
			repeat (4) @(posedge aclk);
			external_count_input <= 0;
			repeat (4) @(posedge aclk);
		end
	endtask
	// ==========================================
	// Sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{external_count_input, sleep, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		rdr(`TCC_OFF_CONTROL);
		chk(rd, 32'h0, 0);
		wr(`TCC_OFF_CONTROL, 32'hff);
		chk(resp, 32'h0, 0);
		rdr(`TCC_OFF_CONTROL);
		chk(rd, 32'hf5, 0);
		// Unmapped offset answers with an error and reads zero
		wr(4'h2, 32'hff);
		chk(resp, 32'h2, 0);
		rdr(4'h2);
		chk(rd, 32'h0, 0);
		chk(resp, 32'h2, 0);
		// Instruction, system and slow sources under every prescale
		for (int i = 0; i < 12; i++) begin
			s = (i < 8) ? 2'(i / 4) : 2'b11;
			p = 2'(i % 4);
			exp = (s == 2'b01 ? 32'd516 : 32'd129) >> p;
			wr(`TCC_OFF_CONTROL, 0);
			wr(`TCC_OFF_COUNT, 0);
			wr(`TCC_OFF_CONTROL, {24'h0, s, p, 4'h1});
			repeat (512) @(posedge aclk);
			wr(`TCC_OFF_CONTROL, 0);
			rdr(`TCC_OFF_COUNT);
			chk(rd, exp, 3);
			prev = rd;
			repeat (40) @(posedge aclk);
			rdr(`TCC_OFF_COUNT);
			chk(rd, prev, 0);
		end
		// Byte lanes: only the upper count byte is taken
		wr(`TCC_OFF_COUNT, 32'h1234);
		s_axi_wstrb <= 4'h2;
		wr(`TCC_OFF_COUNT, 32'habcd);
		s_axi_wstrb <= 4'hf;
		rdr(`TCC_OFF_COUNT);
		chk(rd, 32'hab34, 0);
		for (int b = 0; b < 2; b++) begin
			wr(`TCC_OFF_COUNT, 0);
			wr(`TCC_OFF_CONTROL, {24'h0, 2'b10, 2'b00, 1'b0, b[0], 2'b01});
			pulses(5);
			rdr(`TCC_OFF_COUNT);
			chk(rd, 32'h5, 0);
		end
		wr(`TCC_OFF_MASK, 1);
		rdr(`TCC_OFF_MASK);
		chk(rd, 32'h1, 0);
		wr(`TCC_OFF_COUNT, 32'hfff0);
		wr(`TCC_OFF_CONTROL, 32'h41);
		repeat (30) @(posedge aclk);
		chk(irq, 1, 0);
		wr(`TCC_OFF_CONTROL, 0);
		rdr(`TCC_OFF_COUNT);
		chk(rd, 32'h12, 3);
		// A zero written to the flag leaves it set
		wr(`TCC_OFF_STATUS, 32'h2);
		rdr(`TCC_OFF_STATUS);
		chk(rd, 32'h1, 0);
		rdr(`TCC_OFF_STATUS);
		chk(rd, 32'h0, 0);
		chk(irq, 0, 0);
		// Asleep: the system source freezes, the bypassed pin still counts
		sleep <= 1;
		wr(`TCC_OFF_MASK, 0);
		wr(`TCC_OFF_CONTROL, 32'h41);
		rdr(`TCC_OFF_COUNT);
		prev = rd;
		repeat (20) @(posedge aclk);
		rdr(`TCC_OFF_COUNT);
		chk(rd, prev, 0);
		wr(`TCC_OFF_COUNT, 32'hfffe);
		wr(`TCC_OFF_CONTROL, 32'h85);
		pulses(3);
		chk(wake, 1, 0);
		chk(irq, 0, 0);
		wr(`TCC_OFF_MASK, 32'h2);
		chk(irq, 1, 0);
		wr(`TCC_OFF_STATUS, 32'h2);
		chk(wake, 0, 0);
		chk(irq, 0, 0);
		sleep <= 0;
		rdr(`TCC_OFF_STATUS);
		chk(rd, 32'h1, 0);
		rdr(`TCC_OFF_COUNT);
		chk(rd, 32'h1, 0);
		summarize();
	end
	initial begin
		repeat (30000) @(posedge aclk);
		fails++;
		summarize();
	end
endmodule // tcc_timer_test
